// File: src/pmm_regs.sv
// performance monitor register bank reached by system-register moves
`timescale 1ns/10ps
// Overview of operation
// - 32-bit control view and 64-bit control view share one storage.
// - low seven control bits are mirrored to the external copy.
// - one control register serves secure and non-secure states alike.
// - control register sits in the warm reset domain.
// - control reset values load only when booting into 32-bit state.
// - all registers reached through system-register read and write moves.
// - count enable set and clear registers control enabled counters.
// - overflow status has clear and set forms recording overflow.
// - write-only software increment requests counts of chosen counters.
// - six 32-bit event counters, unknown after reset.
// - six event type registers; a counter typed for software increment also counts increment writes.
// - 64-bit cycle counter, unknown after reset.
// - cycle filter decides when the cycle counter counts.
// - selection register steers selected type and count accesses.
// - two 64-bit read-only common event identification registers.
// - interrupt enable set and clear pick overflows that interrupt.
// - user enable governs access from the least privileged level.
// - divider bit makes cycle counter step once per 64 clocks.
// - counter reset bit zeroes event counters, reads zero, keeps flags.
// - long cycle bit moves cycle overflow from bit 31 to bit 63.
// - global enable low stops all counters; resets to zero on a 32-bit boot.
module pmm_regs #(
    parameter logic [7:0] IMPL_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3c, // arbitrary value
    parameter logic [63:0] CEID_LO_VAL = 64'h0000_0000_0000_0000,
    parameter logic [63:0] CEID_HI_VAL = 64'h0000_0000_0000_0000
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_boot_32bit,
    input wire logic [1:0] i_el,
    input wire logic [pmm_pkg::NCNT-1:0] i_event,
    input wire logic i_sr_wr,
    input wire logic i_sr_rd,
    input wire logic [pmm_pkg::IDX_W-1:0] i_sr_idx,
    input wire logic [63:0] i_sr_wdata,
    output logic [63:0] o_sr_rdata,
    output logic o_sr_rvalid,
    output logic o_sr_denied,
    output logic [pmm_pkg::CTRL_MIRROR_W-1:0] o_ext_ctrl,
    output logic o_irq
);
    localparam int NCNT = pmm_pkg::NCNT;
    localparam int CW = pmm_pkg::CW;

    // true when the index falls in a block of per-counter registers
    function automatic logic in_block(input logic [4:0] idx,
                                      input logic [4:0] base);
        in_block = (idx >= base) && (idx < base + 5'(NCNT));
    endfunction

    // masked 32-bit write data for a set or clear register
    function automatic logic [31:0] hit_bits(input logic hit,
                                             input logic [31:0] d);
        hit_bits = hit ? (d & pmm_pkg::IMPL_MASK) : 32'h0;
    endfunction

    pmm_cnt_if #(.NCNT(NCNT), .CW(CW)) cnt_bus ();

    pmm_evcnt #(.NCNT(NCNT), .CW(CW)) u_evcnt (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .bus(cnt_bus.bank)
    );

    logic ctrl_e_q, ctrl_d_q, ctrl_x_q, ctrl_dp_q, ctrl_lc_q;
    logic [31:0] cnten_q, cnten_d;
    logic [31:0] ovs_q, ovs_d;
    logic [31:0] irqen_q, irqen_d;
    logic [4:0] sel_q;
    logic [NCNT-1:0][31:0] evtype_q;
    logic [31:0] filt_q;
    logic [31:0] usren_q;
    logic [63:0] cycle_counter_q;
    logic [pmm_pkg::PRESC_W-1:0] presc_q;
    logic [63:0] rdata_q, rdata_d;
    logic rvalid_q, denied_q, irq_q;
    logic [pmm_pkg::CTRL_MIRROR_W-1:0] ext_q;

    ////////////////////////////////////////////////////////////////////
    // access check and write decode
    wire [4:0] idx = i_sr_idx;
    wire [31:0] wd = i_sr_wdata[31:0];
    // interrupt enables belong to the kernel level only
    wire el1_only = (idx == pmm_pkg::REG_IRQEN_SET) ||
                    (idx == pmm_pkg::REG_IRQEN_CLR);
    wire at_el0 = (i_el == pmm_pkg::EL0);
    wire acc_ok = !at_el0 ||
                  (usren_q[pmm_pkg::USER_EN_BIT] && !el1_only);
    wire wr = i_sr_wr && acc_ok;
    wire rd = i_sr_rd && acc_ok;
    // both control views decode to the same storage
    wire w_ctrl = wr && (idx == pmm_pkg::REG_CTRL ||
                         idx == pmm_pkg::REG_CTRL32);
    wire sel_ev = sel_q < 5'(NCNT);
    wire sel_cyc = sel_q == pmm_pkg::SEL_CYCLE;
    wire [2:0] sel_n = sel_q[2:0];
    wire [2:0] blk_ev_cnt = 3'(idx - pmm_pkg::REG_EVCNT0);
    wire [2:0] blk_ev_type = 3'(idx - pmm_pkg::REG_EVTYPE0);
    wire w_evcnt_blk = wr && in_block(idx, pmm_pkg::REG_EVCNT0);
    wire w_evcnt_sel = wr && idx == pmm_pkg::REG_SEL_CNT && sel_ev;
    wire w_evtype_blk = wr && in_block(idx, pmm_pkg::REG_EVTYPE0);
    wire w_evtype_sel = wr && idx == pmm_pkg::REG_SEL_TYPE && sel_ev;
    wire w_filt = wr && (idx == pmm_pkg::REG_CFILT ||
                  (idx == pmm_pkg::REG_SEL_TYPE && sel_cyc));
    wire w_swinc = wr && idx == pmm_pkg::REG_SWINC;
    wire cc_wr = wr && idx == pmm_pkg::REG_CYCLE_COUNTER;
    wire cc_clr = w_ctrl && wd[pmm_pkg::CTRL_C];

    ////////////////////////////////////////////////////////////////////
    // set/clear pairs: ones act, zeros do nothing
    wire [31:0] cnten_set = hit_bits(wr && idx == pmm_pkg::REG_CNTEN_SET, wd);
    wire [31:0] cnten_clr = hit_bits(wr && idx == pmm_pkg::REG_CNTEN_CLR, wd);
    wire [31:0] ovs_set = hit_bits(wr && idx == pmm_pkg::REG_OVS_SET, wd);
    wire [31:0] ovs_clr = hit_bits(wr && idx == pmm_pkg::REG_OVS_CLR, wd);
    wire [31:0] irqen_set = hit_bits(wr && idx == pmm_pkg::REG_IRQEN_SET, wd);
    wire [31:0] irqen_clr = hit_bits(wr && idx == pmm_pkg::REG_IRQEN_CLR, wd);

    ////////////////////////////////////////////////////////////////////
    // event counting: global enable, per-counter enable, event or
    // software increment when the counter is typed for it
    logic [NCNT-1:0] swinc_hit;
    always_comb begin
        for (int n = 0; n < NCNT; n++) begin
            swinc_hit[n] = w_swinc && wd[n] &&
                evtype_q[n][9:0] == pmm_pkg::EVT_SW_INCR;
        end
    end
    wire [NCNT-1:0] ev_en = {NCNT{ctrl_e_q}} & cnten_q[NCNT-1:0];
    assign cnt_bus.inc = ev_en & (i_event | swinc_hit);
    assign cnt_bus.clr_all = w_ctrl && wd[pmm_pkg::CTRL_P];
    assign cnt_bus.wr_en = w_evcnt_blk || w_evcnt_sel;
    assign cnt_bus.wr_idx = w_evcnt_blk ? blk_ev_cnt : sel_n;
    assign cnt_bus.wr_data = wd;

    ////////////////////////////////////////////////////////////////////
    // cycle counting: filter by level, optional divide by 64
    wire filt_block = (i_el == pmm_pkg::EL1 &&
                       filt_q[pmm_pkg::FILT_EL1_BIT]) ||
                      (at_el0 && filt_q[pmm_pkg::FILT_EL0_BIT]);
    wire cc_run = ctrl_e_q && cnten_q[pmm_pkg::CYC_BIT] &&
                  !filt_block;
    wire presc_wrap = &presc_q;
    wire cc_inc = cc_run && (!ctrl_d_q || presc_wrap);
    // the overflow boundary moves with the long cycle bit
    wire cc_ovf = cc_inc && !cc_clr && !cc_wr &&
                  (ctrl_lc_q ? (&cycle_counter_q) : (&cycle_counter_q[31:0]));

    ////////////////////////////////////////////////////////////////////
    // next state of the set/clear pairs; hardware set beats a clear
    wire [31:0] hw_ovf = {cc_ovf, 25'h0, cnt_bus.ovf};
    assign cnten_d = (cnten_q & ~cnten_clr) | cnten_set;
    assign irqen_d = (irqen_q & ~irqen_clr) | irqen_set;
    assign ovs_d = (ovs_q & ~ovs_clr) | ovs_set | hw_ovf;

    ////////////////////////////////////////////////////////////////////
    // control fields; p and c are actions and read as zero
    wire [31:0] ctrl_rd = {IMPL_CODE, PART_CODE, pmm_pkg::CTRL_N_VAL, 4'h0,
                           ctrl_lc_q, ctrl_dp_q, ctrl_x_q, ctrl_d_q,
                           2'b00, ctrl_e_q};

    // warm reset loads defined values only on a 32-bit boot; otherwise
    // the fields keep whatever they held, which software sees as unknown
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            if (i_boot_32bit) begin
                {ctrl_lc_q, ctrl_dp_q, ctrl_x_q, ctrl_d_q, ctrl_e_q} <=
                    pmm_pkg::CTRL_FIELDS_RST;
            end
        end else if (w_ctrl) begin
            ctrl_e_q <= wd[pmm_pkg::CTRL_E];
            ctrl_d_q <= wd[pmm_pkg::CTRL_D];
            ctrl_x_q <= wd[pmm_pkg::CTRL_X];
            ctrl_dp_q <= wd[pmm_pkg::CTRL_DP];
            ctrl_lc_q <= wd[pmm_pkg::CTRL_LC];
        end
    end

    // enables and flags start clear so no stale interrupt appears
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cnten_q <= 32'h0;
            ovs_q <= 32'h0;
            irqen_q <= 32'h0;
            sel_q <= 5'h00;
            usren_q <= 32'h0;
            filt_q <= 32'h0;
        end else begin
            cnten_q <= cnten_d;
            ovs_q <= ovs_d;
            irqen_q <= irqen_d;
            if (wr && idx == pmm_pkg::REG_SEL) begin
                sel_q <= wd[4:0];
            end
            if (wr && idx == pmm_pkg::REG_USER_EN) begin
                usren_q <= wd;
            end
            if (w_filt) begin
                filt_q <= wd;
            end
        end
    end

    // event types carry no reset
    always_ff @(posedge i_mclk) begin
        for (int n = 0; n < NCNT; n++) begin
            if ((w_evtype_blk && blk_ev_type == 3'(n)) ||
                (w_evtype_sel && sel_n == 3'(n))) begin
                evtype_q[n] <= wd;
            end
        end
    end

    // cycle counter has no reset; a c-bit write zeroes it, flags stay
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            presc_q <= '0;
        end else if (cc_run) begin
            presc_q <= presc_q + 1'b1;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (cc_wr) begin
            cycle_counter_q <= i_sr_wdata;
        end else if (cc_clr) begin
            cycle_counter_q <= 64'h0;
        end else if (cc_inc) begin
            cycle_counter_q <= cycle_counter_q + 64'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data select; unmapped and write-only indices read zero
    always_comb begin
        rdata_d = 64'h0;
        if (in_block(idx, pmm_pkg::REG_EVCNT0)) begin
            rdata_d = {32'h0, cnt_bus.count[blk_ev_cnt]};
        end else if (in_block(idx, pmm_pkg::REG_EVTYPE0)) begin
            rdata_d = {32'h0, evtype_q[blk_ev_type]};
        end else begin
            case (idx)
                pmm_pkg::REG_CTRL, pmm_pkg::REG_CTRL32: begin
                    rdata_d = {32'h0, ctrl_rd};
                end
                pmm_pkg::REG_CNTEN_SET, pmm_pkg::REG_CNTEN_CLR: begin
                    rdata_d = {32'h0, cnten_q};
                end
                pmm_pkg::REG_OVS_SET, pmm_pkg::REG_OVS_CLR: begin
                    rdata_d = {32'h0, ovs_q};
                end
                pmm_pkg::REG_IRQEN_SET, pmm_pkg::REG_IRQEN_CLR: begin
                    rdata_d = {32'h0, irqen_q};
                end
                pmm_pkg::REG_SEL: rdata_d = {59'h0, sel_q};
                pmm_pkg::REG_CEID_LO: rdata_d = CEID_LO_VAL;
                pmm_pkg::REG_CEID_HI: rdata_d = CEID_HI_VAL;
                pmm_pkg::REG_CYCLE_COUNTER: rdata_d = cycle_counter_q;
                pmm_pkg::REG_CFILT: rdata_d = {32'h0, filt_q};
                pmm_pkg::REG_USER_EN: rdata_d = {32'h0, usren_q};
                pmm_pkg::REG_SEL_TYPE: begin
                    if (sel_ev) begin
                        rdata_d = {32'h0, evtype_q[sel_n]};
                    end else if (sel_cyc) begin
                        rdata_d = {32'h0, filt_q};
                    end
                end
                pmm_pkg::REG_SEL_CNT: begin
                    if (sel_ev) begin
                        rdata_d = {32'h0, cnt_bus.count[sel_n]};
                    end
                end
                default: rdata_d = 64'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rdata_q <= 64'h0;
            rvalid_q <= 1'b0;
            denied_q <= 1'b0;
            irq_q <= 1'b0;
            ext_q <= '0;
        end else begin
            rdata_q <= rd ? rdata_d : 64'h0;
            rvalid_q <= rd;
            denied_q <= (i_sr_rd || i_sr_wr) && !acc_ok;
            irq_q <= |(ovs_q & irqen_q);
            ext_q <= ctrl_rd[pmm_pkg::CTRL_MIRROR_W-1:0];
        end
    end
    assign o_sr_rdata = rdata_q;
    assign o_sr_rvalid = rvalid_q;
    assign o_sr_denied = denied_q;
    assign o_irq = irq_q;
    assign o_ext_ctrl = ext_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    view_alias_a: assert property (
        (wr && idx == pmm_pkg::REG_CTRL32) |=>
        ctrl_lc_q == $past(wd[pmm_pkg::CTRL_LC]) &&
        ctrl_e_q == $past(wd[pmm_pkg::CTRL_E]))
        else $error("32-bit control view not shared");

    ext_mirror_a: assert property (
        w_ctrl ##1 !w_ctrl |=> o_ext_ctrl ==
        ($past(wd[6:0], 2) & 7'h79))
        else $error("external control copy mismatch");

    // reset itself is the trigger here, so the default disable is overridden
    boot_reset_a: assert property (
        @(posedge i_mclk) disable iff (1'b0)
        (i_srst && i_boot_32bit) |=>
        !ctrl_e_q && !ctrl_d_q && !ctrl_lc_q)
        else $error("control fields not reset on 32-bit boot");

    set_clear_a: assert property (
        (wr && idx == pmm_pkg::REG_CNTEN_SET) |=>
        ((cnten_q & $past(wd & pmm_pkg::IMPL_MASK)) ==
         $past(wd & pmm_pkg::IMPL_MASK)))
        else $error("count enable set lost a bit");

    ovf_irq_a: assert property (
        (cnt_bus.ovf != '0 && (irqen_q[NCNT-1:0] & cnt_bus.ovf) != '0)
        |=> ovs_q[NCNT-1:0] != '0 ##1 o_irq)
        else $error("overflow did not raise interrupt");

    div_step_a: assert property (
        (cc_inc && ctrl_d_q) |=> (!cc_inc || !ctrl_d_q) [*8])
        else $error("divided cycle counter stepped too soon");

    short_ovf_a: assert property (
        (cc_inc && !cc_wr && !cc_clr && !ctrl_lc_q &&
         cycle_counter_q[31:0] == 32'hffff_ffff) |=> ovs_q[pmm_pkg::CYC_BIT])
        else $error("32-bit cycle overflow not flagged");

    global_off_a: assert property (
        (!ctrl_e_q && cnten_q[pmm_pkg::CYC_BIT] && !cc_wr && !cc_clr)
        |=> $stable(cycle_counter_q))
        else $error("cycle counter ran while disabled");

    user_block_a: assert property (
        (at_el0 && !usren_q[pmm_pkg::USER_EN_BIT] && i_sr_rd) |=>
        o_sr_denied && !o_sr_rvalid)
        else $error("user access not refused");
endmodule

// File: src/pmm_pkg.sv
// shared constants of the performance monitor register bank
package pmm_pkg;
    localparam int NCNT = 6;
    localparam int CW = 32;
    localparam int CCW = 64;
    localparam int IDX_W = 5;
    // system-register index of every register
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CTRL32 = 5'h01;
    localparam logic [4:0] REG_CNTEN_SET = 5'h02;
    localparam logic [4:0] REG_CNTEN_CLR = 5'h03;
    localparam logic [4:0] REG_OVS_CLR = 5'h04;
    localparam logic [4:0] REG_SWINC = 5'h05;
    localparam logic [4:0] REG_SEL = 5'h06;
    localparam logic [4:0] REG_CEID_LO = 5'h07;
    localparam logic [4:0] REG_CEID_HI = 5'h08;
    localparam logic [4:0] REG_CYCLE_COUNTER = 5'h09;
    localparam logic [4:0] REG_SEL_TYPE = 5'h0a;
    localparam logic [4:0] REG_CFILT = 5'h0b;
    localparam logic [4:0] REG_SEL_CNT = 5'h0c;
    localparam logic [4:0] REG_USER_EN = 5'h0d;
    localparam logic [4:0] REG_IRQEN_SET = 5'h0e;
    localparam logic [4:0] REG_IRQEN_CLR = 5'h0f;
    localparam logic [4:0] REG_OVS_SET = 5'h10;
    localparam logic [4:0] REG_EVCNT0 = 5'h11;
    localparam logic [4:0] REG_EVTYPE0 = 5'h17;
    // control register fields
    localparam int CTRL_E = 0;
    localparam int CTRL_P = 1;
    localparam int CTRL_C = 2;
    localparam int CTRL_D = 3;
    localparam int CTRL_X = 4;
    localparam int CTRL_DP = 5;
    localparam int CTRL_LC = 6;
    localparam int CTRL_MIRROR_W = 7;
    localparam logic [4:0] CTRL_N_VAL = 5'h06;
    localparam logic [4:0] CTRL_FIELDS_RST = 5'h00;
    // enable/overflow bit layout: counters in low bits, cycle counter 31
    localparam int CYC_BIT = 31;
    localparam logic [31:0] IMPL_MASK = 32'h8000_003f;
    // cycle divider and filter
    localparam int DIV_CYCLES = 64;
    localparam int PRESC_W = $clog2(DIV_CYCLES);
    localparam int FILT_EL1_BIT = 31;
    localparam int FILT_EL0_BIT = 30;
    localparam logic [4:0] SEL_CYCLE = 5'h1f;
    localparam int USER_EN_BIT = 0;
    localparam logic [9:0] EVT_SW_INCR = 10'h000;
    localparam logic [1:0] EL0 = 2'h0;
    localparam logic [1:0] EL1 = 2'h1;
endpackage

// File: src/pmm_cnt_if.sv
// link between the register bank and the event counter array
`timescale 1ns/10ps
interface pmm_cnt_if #(
    parameter int NCNT = 6,
    parameter int CW = 32
);
    logic [NCNT-1:0] inc;
    logic clr_all;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [CW-1:0] wr_data;
    logic [NCNT-1:0][CW-1:0] count;
    logic [NCNT-1:0] ovf;
    modport ctl (output inc, clr_all, wr_en, wr_idx, wr_data,
                 input count, ovf);
    modport bank (input inc, clr_all, wr_en, wr_idx, wr_data,
                  output count, ovf);
endinterface

// File: src/pmm_evcnt.sv
// array of event counters with wrap detection
`timescale 1ns/10ps
module pmm_evcnt #(
    parameter int NCNT = 6,
    parameter int CW = 32
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    pmm_cnt_if.bank bus
);
    logic [NCNT-1:0][CW-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////
    // counters carry no reset: their value after reset is unknown
    always_ff @(posedge i_mclk) begin
        for (int n = 0; n < NCNT; n++) begin
            if (bus.clr_all) begin
                cnt_q[n] <= '0;
            end else if (bus.wr_en && bus.wr_idx == 3'(n)) begin
                cnt_q[n] <= bus.wr_data;
            end else if (bus.inc[n]) begin
                cnt_q[n] <= cnt_q[n] + 1'b1;
            end
        end
    end

    // a wrap only counts when no reset or write overrides the increment
    always_comb begin
        for (int n = 0; n < NCNT; n++) begin
            bus.ovf[n] = bus.inc[n] && (&cnt_q[n]) && !bus.clr_all &&
                         !(bus.wr_en && bus.wr_idx == 3'(n));
        end
    end
    assign bus.count = cnt_q;

    ////////////////////////////////////////////////////////////////////
    // a counter reset clears every event counter on the next edge
    ev_reset_a: assert property (@(posedge i_mclk) disable iff (i_srst)
        bus.clr_all |=> (cnt_q == '0))
        else $error("event counters not zeroed by counter reset");
endmodule

// File: testbench/pmm_regs_tb.sv
// self-checking bench for the performance monitor register bank
`timescale 1ns/10ps
module pmm_regs_tb;
    logic i_mclk, i_srst, i_boot_32bit, i_sr_wr, i_sr_rd;
    logic [1:0] i_el;
    logic [5:0] i_event;
    logic [4:0] i_sr_idx;
    logic [63:0] i_sr_wdata, o_sr_rdata, q, d, m;
    logic o_sr_rvalid, o_sr_denied, o_irq, dn;
    logic [6:0] o_ext_ctrl;
    logic [4:0] set_tab [3];
    logic [4:0] clr_tab [3];
    int fails, n_compared, seed;
    pmm_regs dut_u (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_boot_32bit(i_boot_32bit), .i_el(i_el), .i_event(i_event),
        .i_sr_wr(i_sr_wr), .i_sr_rd(i_sr_rd), .i_sr_idx(i_sr_idx),
        .i_sr_wdata(i_sr_wdata), .o_sr_rdata(o_sr_rdata),
        .o_sr_rvalid(o_sr_rvalid), .o_sr_denied(o_sr_denied),
        .o_ext_ctrl(o_ext_ctrl), .o_irq(o_irq));
    ////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // control read value: codes are the arbitrary defaults, p and c read 0
    function automatic logic [63:0] ctrl_exp(input logic [6:0] f);
        return {32'h0, 8'h5a, 8'h3c, 5'h06, 4'h0, f & 7'h79};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] e);
        n_compared++;
        if (seen !== e) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, e);
        end
    endtask
    // strobes move 1 ns after the edge; answer sampled after the next edge
    task automatic wr(input logic [4:0] idx, input logic [63:0] v);
        @(posedge i_mclk);
        #1;
        i_sr_wr = 1'b1;
        i_sr_idx = idx;
        i_sr_wdata = v;
        @(posedge i_mclk);
        #1;
        i_sr_wr = 1'b0;
        dn = o_sr_denied;
    endtask
    task automatic rd(input logic [4:0] idx);
        @(posedge i_mclk);
        #1;
        i_sr_rd = 1'b1;
        i_sr_idx = idx;
        @(posedge i_mclk);
        #1;
        i_sr_rd = 1'b0;
        dn = o_sr_denied;
        q = (o_sr_rvalid === 1'b1) ? o_sr_rdata : 64'h0bad;
    endtask
    task automatic rchk(input logic [4:0] idx, input logic [63:0] e);
        rd(idx);
        chk(q, e);
    endtask
    task automatic ev(input logic [5:0] v);
        @(posedge i_mclk);
        #1;
        i_event = v;
        @(posedge i_mclk);
        #1;
        i_event = 6'h00;
    endtask
    // runs the cycle counter for n+2 clocks, then reads it back into q
    task automatic cyc_run(input int n);
        wr(pmm_pkg::REG_CNTEN_SET, 64'h8000_0000);
        repeat (n) @(posedge i_mclk);
        wr(pmm_pkg::REG_CNTEN_CLR, 64'h8000_0000);
        rd(pmm_pkg::REG_CYCLE_COUNTER);
    endtask
    task automatic do_reset(input logic boot, input int n);
        @(posedge i_mclk);
        #1;
        i_srst = 1'b1;
        i_boot_32bit = boot;
        repeat (n) @(posedge i_mclk);
        #1;
        i_srst = 1'b0;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hf71b;
        i_srst = 1'b1;
        i_boot_32bit = 1'b1;
        {i_sr_wr, i_sr_rd, i_event, i_sr_idx, i_sr_wdata} = '0;
        i_el = pmm_pkg::EL1;
        set_tab = '{pmm_pkg::REG_CNTEN_SET, pmm_pkg::REG_OVS_SET,
            pmm_pkg::REG_IRQEN_SET};
        clr_tab = '{pmm_pkg::REG_CNTEN_CLR, pmm_pkg::REG_OVS_CLR,
            pmm_pkg::REG_IRQEN_CLR};
        do_reset(1'b1, 6);
        rchk(pmm_pkg::REG_CTRL, ctrl_exp(7'h00));
        chk(o_ext_ctrl, 7'h00);
        wr(pmm_pkg::REG_CTRL32, 64'h7f);
        rchk(pmm_pkg::REG_CTRL, ctrl_exp(7'h7f));
        chk(o_ext_ctrl, 7'h79);
        wr(pmm_pkg::REG_CTRL, 64'h0);
        rchk(pmm_pkg::REG_CTRL32, ctrl_exp(7'h00));
        $display("test control views done");
        // random set/clear pairs; unimplemented bits must read 0
        for (int k = 0; k < 3; k++) begin
            d = {32'h0, $random(seed)} & pmm_pkg::IMPL_MASK;
            m = {32'h0, $random(seed)};
            wr(set_tab[k], d | 64'h7fff_ffc0);
            rchk(clr_tab[k], d);
            wr(clr_tab[k], m);
            rchk(set_tab[k], d & ~m);
            wr(clr_tab[k], 64'hffff_ffff);
            rchk(set_tab[k], 64'h0);
        end
        $display("test set clear done");
        for (int i = 0; i < 6; i++) begin
            d = {32'h0, $random(seed)};
            wr(pmm_pkg::REG_SEL, 64'(i));
            wr(pmm_pkg::REG_SEL_CNT, d);
            rchk(pmm_pkg::REG_EVCNT0 + 5'(i), d);
            wr(pmm_pkg::REG_SEL_TYPE, 64'h0);
            rchk(pmm_pkg::REG_EVTYPE0 + 5'(i), 64'h0);
        end
        $display("test counters done");
        // counter 0 wraps on its second event and raises the interrupt
        wr(pmm_pkg::REG_EVCNT0, 64'hffff_fffe);
        wr(pmm_pkg::REG_CNTEN_SET, 64'h1);
        wr(pmm_pkg::REG_IRQEN_SET, 64'h1);
        wr(pmm_pkg::REG_CTRL, 64'h1);
        ev(6'h3f);
        rchk(pmm_pkg::REG_EVCNT0, 64'hffff_ffff);
        chk(o_irq, 1'b0);
        ev(6'h01);
        rchk(pmm_pkg::REG_OVS_SET, 64'h1);
        chk(o_irq, 1'b1);
        wr(pmm_pkg::REG_CTRL, 64'h3);
        rchk(pmm_pkg::REG_EVCNT0 + 5'd2, 64'h0);
        rchk(pmm_pkg::REG_OVS_CLR, 64'h1);
        chk(o_irq, 1'b1);
        wr(pmm_pkg::REG_OVS_CLR, 64'h1);
        @(posedge i_mclk);
        #1;
        chk(o_irq, 1'b0);
        wr(pmm_pkg::REG_CNTEN_SET, 64'h2);
        wr(pmm_pkg::REG_SWINC, 64'ha);
        rchk(pmm_pkg::REG_EVCNT0 + 5'd1, 64'h1);
        rchk(pmm_pkg::REG_EVCNT0 + 5'd3, 64'h0);
        $display("test overflow done");
        // cycle counter: 32-bit then 64-bit overflow point
        wr(pmm_pkg::REG_CYCLE_COUNTER, 64'hffff_fff0);
        cyc_run(40);
        chk(q[63:32], 32'h1);
        rchk(pmm_pkg::REG_OVS_SET, 64'h8000_0000);
        wr(pmm_pkg::REG_OVS_CLR, 64'hffff_ffff);
        wr(pmm_pkg::REG_CTRL, 64'h41);
        wr(pmm_pkg::REG_CYCLE_COUNTER, 64'hffff_fff0);
        cyc_run(40);
        rchk(pmm_pkg::REG_OVS_SET, 64'h0);
        wr(pmm_pkg::REG_CTRL, 64'h9);
        wr(pmm_pkg::REG_CYCLE_COUNTER, 64'h0);
        cyc_run(200);
        chk(q >= 64'd3 && q <= 64'd4, 1'b1);
        wr(pmm_pkg::REG_CTRL, 64'h1);
        wr(pmm_pkg::REG_CFILT, 64'h8000_0000);
        wr(pmm_pkg::REG_CYCLE_COUNTER, 64'h0);
        cyc_run(20);
        chk(q, 64'h0);
        $display("test cycle counter done");
        // user level access and read-only places
        i_el = pmm_pkg::EL0;
        rd(pmm_pkg::REG_CTRL);
        chk({dn, q}, {1'b1, 64'h0bad});
        i_el = pmm_pkg::EL1;
        wr(pmm_pkg::REG_USER_EN, 64'h1);
        i_el = pmm_pkg::EL0;
        rchk(pmm_pkg::REG_CNTEN_SET, 64'h3);
        wr(pmm_pkg::REG_IRQEN_SET, 64'h2);
        chk(dn, 1'b1);
        i_el = pmm_pkg::EL1;
        rchk(pmm_pkg::REG_IRQEN_SET, 64'h1);
        wr(pmm_pkg::REG_CEID_LO, 64'hffff_ffff_ffff_ffff);
        rchk(pmm_pkg::REG_CEID_LO, 64'h0);
        rchk(pmm_pkg::REG_CEID_HI, 64'h0);
        rchk(5'h1d, 64'h0);
        $display("test access done");
        do_reset(1'b0, 2);
        chk(o_ext_ctrl, 7'h01);
        do_reset(1'b1, 2);
        chk(o_ext_ctrl, 7'h00);
        $display("test warm reset done");
        give_verdict();
    end
endmodule
